// ---- logic/lpw_cfg.svh ----
/*
  low-power wake control: register offsets, bit positions, reset values
  and timing figures.
  assumes a 32-bit AHB-Lite bus and a 25 MHz hclk.
*/
`ifndef LPW_CFG_SVH
`define LPW_CFG_SVH

// register byte offsets
`define LPW_OFS_RCAUSE   8'h00
`define LPW_OFS_OSCCTL   8'h04
`define LPW_OFS_CORECTL  8'h08
`define LPW_OFS_IRQ_STAT 8'h0c
`define LPW_OFS_IRQ_MASK 8'h10
`define LPW_OFS_CLKSTAT  8'h14

// reset cause register bits
`define LPW_RC_IDLE_BIT  2
`define LPW_RC_SLEEP_BIT 3
`define LPW_RC_WDOG_BIT  4

// oscillator control register bits
`define LPW_OC_DEEP_BIT  4
`define LPW_OC_MODE_LSB  0
`define LPW_OC_MODE_W    3

// core control register bits
`define LPW_CC_PRIO_LSB  0
`define LPW_CC_PRIO_W    3

// interrupt status bits
`define LPW_IS_WAKE_BIT  0
`define LPW_IS_WDOG_BIT  1
`define LPW_IS_FAILSAFE_CLOCK_MONITOR_BIT  2
`define LPW_IS_BLK_BIT   3
`define LPW_IS_W         4

// reset values
`define LPW_RST_MODE     3'h0
`define LPW_RST_PRIO     3'h0
`define LPW_RST_MASK     4'h0

// oscillator start-up delay, 20 us; 25 MHz clock
`define LPW_OST_NS       20000
`define LPW_CLK_NS       40
`define LPW_OST_CYC      ((`LPW_OST_NS + `LPW_CLK_NS - 1) / `LPW_CLK_NS)
`define LPW_CNT_W        16

// halt entry takes this many cycles to settle
`define LPW_ENTRY_CYC    2

`endif

// ---- logic/lpw_pkg.sv ----
/*
  low-power wake control: shared types.
  assumes lpw_cfg.svh for the figures.
*/
package lpw_pkg;

  typedef enum logic [2:0] {
    LPW_RUN,
    LPW_ENTER,
    LPW_HALT,
    LPW_OSC_WAIT,
    LPW_WAKE
  } lpw_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        sel;
  } lpw_aphase_t;

  typedef struct packed {
    logic       wdog_flag;
    logic       sleep_flag;
    logic       idle_flag;
  } lpw_cause_t;

endpackage

// ---- logic/lpw_wake_ctrl.sv ----
/*
  low-power wake control: tracks cpu halt (sleep and idle), turns a
  watchdog expiry while halted into an nmi to the reset vector, records
  wake causes, clears the watchdog on wake and gates clock-mode writes
  while a debugger is attached. registers over AHB-Lite.
  assumes the cpu asserts halt_req for one cycle per halt instruction and
  that the watchdog and interrupt controller sit on the same hclk.
*/
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "lpw_cfg.svh"

//Contract
// RQ1 - watchdog expiry while halted raises an nmi, not a reset
// RQ2 - that nmi redirects the cpu to the reset vector
// RQ3 - watchdog wake never asserts a device reset; state kept
// RQ4 - cpu execution held until oscillator start-up delay has elapsed
// RQ5 - watchdog flag bit 4 of reset cause register set on watchdog wake
// RQ6 - sleep bit 3 and idle bit 2 tell where the watchdog wake occurred
// RQ7 - software returns by exception return; cpu resumes after halt
// RQ8 - watchdog count cleared automatically on every wake
// RQ9 - interrupt and expiry together may wake by interrupt, no nmi
// RQ10 - interrupt during halt instruction held until entry completes
// RQ11 - held interrupt wakes the device right after entry completes
// RQ12 - software clock mode changes blocked while debugger is active
// RQ13 - fail-safe clock monitor switches still apply under debugger
// RQ14 - no dedicated pins; only instructions, interrupts, watchdog
// RQ15 - halt with deep halt select bit clear enters idle, not sleep
// RQ16 - interrupt wakes only if priority exceeds cpu priority
// RQ17 - interrupt with priority zero never wakes the device
// RQ18 - idle wake sets idle flag; sleep wake sets sleep and idle
// RQ19 - cause flags stay set until software clears or reset
module lpw_wake_ctrl #(
  parameter int unsigned OST_CYC = `LPW_OST_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        halt_req,
  input  wire logic        irq_req,
  input  wire logic [2:0]  irq_prio,
  input  wire logic        wdog_expire,
  input  wire logic        dbg_active,
  input  wire logic        failsafe_clock_monitor_switch,
  input  wire logic [2:0]  failsafe_clock_monitor_mode,
  input  wire logic        osc_needs_start,
  output logic             cpu_halted,
  output logic             cpu_sleep,
  output logic             nmi_reset_vec,
  output logic             irq_wake,
  output logic             wdog_clear,
  output logic [2:0]       clk_mode,
  output logic             irq
);

  typedef struct packed {
    lpw_pkg::lpw_state_t   st;
    lpw_pkg::lpw_aphase_t  ap;
    lpw_pkg::lpw_cause_t   cause;
    logic                  deep;
    logic                  in_sleep;
    logic [2:0]            mode;
    logic [2:0]            prio;
    logic [`LPW_IS_W-1:0]  stat;
    logic [`LPW_IS_W-1:0]  mask;
    logic                  irq_held;
    logic                  via_wdog;
    logic [`LPW_CNT_W-1:0] cnt;
    logic [31:0]           rdata;
    logic                  halted;
    logic                  nmi;
    logic                  wake;
    logic                  wclr;
    logic                  irq;
  } lpw_regs_t;

  lpw_regs_t cur_ff;
  lpw_regs_t nxt_cur;

  logic [7:0] wofs;
  logic       wr_go;
  logic       rd_go;
  logic       irq_ok;
  logic [`LPW_IS_W-1:0] ev;

  always_comb begin
    nxt_cur = cur_ff;
    ev      = '0;
    wofs    = cur_ff.ap.addr[7:0];
    wr_go   = cur_ff.ap.sel & cur_ff.ap.write;
    rd_go   = hsel & hready & htrans[1] & ~hwrite;
    // RQ16 RQ17 priority gate
    irq_ok  = irq_req && (irq_prio != 3'h0) && (irq_prio > cur_ff.prio);

    nxt_cur.nmi  = 1'b0;
    nxt_cur.wake = 1'b0;
    nxt_cur.wclr = 1'b0;

    nxt_cur.ap.sel   = hsel & hready & htrans[1];
    nxt_cur.ap.addr  = haddr;
    nxt_cur.ap.write = hwrite;

    if (wr_go) begin
      unique case (wofs)
        `LPW_OFS_RCAUSE: begin
          // RQ19 software clears flags
          nxt_cur.cause.wdog_flag  = hwdata[`LPW_RC_WDOG_BIT];
          nxt_cur.cause.sleep_flag = hwdata[`LPW_RC_SLEEP_BIT];
          nxt_cur.cause.idle_flag  = hwdata[`LPW_RC_IDLE_BIT];
        end
        `LPW_OFS_OSCCTL: begin
          nxt_cur.deep = hwdata[`LPW_OC_DEEP_BIT];
          // RQ12 debugger blocks mode writes
          if (!dbg_active) begin
            nxt_cur.mode = hwdata[`LPW_OC_MODE_LSB +: `LPW_OC_MODE_W];
          end else begin
            ev[`LPW_IS_BLK_BIT] = 1'b1;
          end
        end
        `LPW_OFS_CORECTL:
          nxt_cur.prio = hwdata[`LPW_CC_PRIO_LSB +: `LPW_CC_PRIO_W];
        `LPW_OFS_IRQ_MASK:
          nxt_cur.mask = hwdata[`LPW_IS_W-1:0];
        default: ;
      endcase
    end

    // RQ13 fail-safe monitor always wins
    if (failsafe_clock_monitor_switch) begin
      nxt_cur.mode = failsafe_clock_monitor_mode;
      ev[`LPW_IS_FAILSAFE_CLOCK_MONITOR_BIT] = 1'b1;
    end

    unique case (cur_ff.st)
      lpw_pkg::LPW_RUN: begin
        if (halt_req) begin
          // RQ15 select sleep or idle
          nxt_cur.in_sleep = cur_ff.deep;
          nxt_cur.halted   = 1'b1;
          nxt_cur.irq_held = 1'b0;
          nxt_cur.cnt      = `LPW_CNT_W'(`LPW_ENTRY_CYC);
          nxt_cur.st       = lpw_pkg::LPW_ENTER;
        end
      end
      lpw_pkg::LPW_ENTER: begin
        // RQ10 hold coincident interrupt
        if (irq_ok) begin
          nxt_cur.irq_held = 1'b1;
        end
        nxt_cur.cnt = cur_ff.cnt - `LPW_CNT_W'(1);
        if (cur_ff.cnt == `LPW_CNT_W'(1)) begin
          nxt_cur.st = lpw_pkg::LPW_HALT;
        end
      end
      lpw_pkg::LPW_HALT: begin
        // RQ11 RQ9 interrupt wake has priority over the nmi
        if (cur_ff.irq_held || irq_ok) begin
          nxt_cur.via_wdog = 1'b0;
          nxt_cur.st       = lpw_pkg::LPW_OSC_WAIT;
        end else if (wdog_expire) begin
          // RQ1 RQ3 expiry becomes an nmi, no reset
          nxt_cur.via_wdog = 1'b1;
          nxt_cur.st       = lpw_pkg::LPW_OSC_WAIT;
        end
        if (nxt_cur.st == lpw_pkg::LPW_OSC_WAIT) begin
          // RQ8 clear watchdog on wake
          nxt_cur.wclr = 1'b1;
          // RQ4 oscillator start-up delay only from sleep
          nxt_cur.cnt  = (cur_ff.in_sleep && osc_needs_start) ?
                         `LPW_CNT_W'(OST_CYC) : `LPW_CNT_W'(0);
          // RQ18 RQ5 RQ6 cause flags
          nxt_cur.cause.idle_flag = 1'b1;
          if (cur_ff.in_sleep) begin
            nxt_cur.cause.sleep_flag = 1'b1;
          end
          if (nxt_cur.via_wdog) begin
            nxt_cur.cause.wdog_flag = 1'b1;
          end
        end
      end
      lpw_pkg::LPW_OSC_WAIT: begin
        // RQ4 hold execution for start-up
        if (cur_ff.cnt == '0) begin
          nxt_cur.st = lpw_pkg::LPW_WAKE;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - `LPW_CNT_W'(1);
        end
      end
      lpw_pkg::LPW_WAKE: begin
        nxt_cur.halted   = 1'b0;
        nxt_cur.in_sleep = 1'b0;
        nxt_cur.irq_held = 1'b0;
        // RQ2 nmi steers to reset vector; RQ7 software does the return
        nxt_cur.nmi  = cur_ff.via_wdog;
        nxt_cur.wake = ~cur_ff.via_wdog;
        ev[`LPW_IS_WAKE_BIT] = 1'b1;
        ev[`LPW_IS_WDOG_BIT] = cur_ff.via_wdog;
        nxt_cur.st = lpw_pkg::LPW_RUN;
      end
      default: nxt_cur.st = lpw_pkg::LPW_RUN;
    endcase

    // read clears status; a new event on the same cycle wins
    if (rd_go && (haddr[7:0] == `LPW_OFS_IRQ_STAT)) begin
      nxt_cur.stat = '0;
    end
    nxt_cur.stat = nxt_cur.stat | ev[`LPW_IS_W-1:0];
    nxt_cur.irq  = |(nxt_cur.stat & nxt_cur.mask);

    nxt_cur.rdata = '0;
    if (rd_go) begin
      unique case (haddr[7:0])
        `LPW_OFS_RCAUSE: begin
          nxt_cur.rdata[`LPW_RC_WDOG_BIT]  = cur_ff.cause.wdog_flag;
          nxt_cur.rdata[`LPW_RC_SLEEP_BIT] = cur_ff.cause.sleep_flag;
          nxt_cur.rdata[`LPW_RC_IDLE_BIT]  = cur_ff.cause.idle_flag;
        end
        `LPW_OFS_OSCCTL: begin
          nxt_cur.rdata[`LPW_OC_DEEP_BIT] = cur_ff.deep;
          nxt_cur.rdata[`LPW_OC_MODE_LSB +: `LPW_OC_MODE_W] = cur_ff.mode;
        end
        `LPW_OFS_CORECTL:
          nxt_cur.rdata[`LPW_CC_PRIO_LSB +: `LPW_CC_PRIO_W] = cur_ff.prio;
        `LPW_OFS_IRQ_STAT:
          nxt_cur.rdata[`LPW_IS_W-1:0] = cur_ff.stat | ev[`LPW_IS_W-1:0];
        `LPW_OFS_IRQ_MASK:
          nxt_cur.rdata[`LPW_IS_W-1:0] = cur_ff.mask;
        `LPW_OFS_CLKSTAT:
          nxt_cur.rdata[5:0] = {cur_ff.halted, cur_ff.in_sleep,
                                dbg_active, cur_ff.mode};
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff      <= '0;
      cur_ff.st   <= lpw_pkg::LPW_RUN;
      cur_ff.mode <= `LPW_RST_MODE;
      cur_ff.prio <= `LPW_RST_PRIO;
      cur_ff.mask <= `LPW_RST_MASK;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // RQ14 all wake control is internal logic, no pins
  assign hrdata        = cur_ff.rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign cpu_halted    = cur_ff.halted;
  assign cpu_sleep     = cur_ff.in_sleep;
  assign nmi_reset_vec = cur_ff.nmi;
  assign irq_wake      = cur_ff.wake;
  assign wdog_clear    = cur_ff.wclr;
  assign clk_mode      = cur_ff.mode;
  assign irq           = cur_ff.irq;

endmodule

// ---- tb/lpw_chk.sv ----
/*
  checker for lpw_wake_ctrl: wake pulses, start-up wait, entry hold and
  the debugger clock-mode guard. bound in by the bench; one hclk domain.
*/
`timescale 1ns/1ps
module lpw_chk #(
  parameter int unsigned OST_CYC = 4
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       dbg_active,
  input wire logic       failsafe_clock_monitor_switch,
  input wire logic       osc_needs_start,
  input wire logic       cpu_halted,
  input wire logic       cpu_sleep,
  input wire logic       nmi_reset_vec,
  input wire logic       irq_wake,
  input wire logic       wdog_clear,
  input wire logic [2:0] clk_mode
);
  localparam int WD = OST_CYC + 2;
  logic wk;
  assign wk = nmi_reset_vec | irq_wake;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_nmi_halt: assert property (
    nmi_reset_vec |-> $past(cpu_halted) && !cpu_halted)
    else $error("nmi outside halt");
  chk_wake_pulse: assert property (wk |=> !wk)
    else $error("wake pulse too long");
  chk_wake_excl: assert property (!(nmi_reset_vec && irq_wake))
    else $error("nmi and irq wake together");
  chk_clr_wake: assert property (wdog_clear |-> ##[2:8] wk)
    else $error("clear without wake");
  chk_fast_wake: assert property (
    wdog_clear && !(cpu_sleep && osc_needs_start) |-> ##2 wk)
    else $error("short wake late");
  chk_ost_wait: assert property (
    wdog_clear && cpu_sleep && osc_needs_start |-> ##WD wk)
    else $error("start-up wait wrong");
  chk_entry_hold: assert property (
    $rose(cpu_halted) |-> cpu_halted[*4])
    else $error("halt entry cut short");
  chk_dbg_mode: assert property (
    $changed(clk_mode) && $past(dbg_active)
      |-> $past(failsafe_clock_monitor_switch) || $past(failsafe_clock_monitor_switch, 2))
    else $error("mode changed under debugger");
  chk_sleep_hold: assert property (
    cpu_halted && $past(cpu_halted) |-> $stable(cpu_sleep))
    else $error("halt kind moved");
endmodule

// ---- tb/lpw_cpu_model.sv ----
/*
  stand-in for the cpu core and interrupt controller: turns bench commands
  into halt instructions and a pending interrupt level.
  assumes hclk and hresetn are shared with the wake controller.
*/
`timescale 1ns/1ps
module lpw_cpu_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       go_halt,
  input  wire logic       irq_on,
  input  wire logic [2:0] prio_in,
  input  wire logic       irq_wake,
  output logic            halt_req,
  output logic            irq_req,
  output logic      [2:0] irq_prio
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_req <= 1'b0;
      irq_req  <= 1'b0;
      irq_prio <= 3'h0;
    end else begin
      halt_req <= go_halt;
      irq_req  <= irq_on & ~irq_wake;
      // priority means nothing when idle, so let it wander
      irq_prio <= irq_on ? prio_in : ~irq_prio;
    end
  end
endmodule

// ---- tb/lpw_wake_ctrl_bench.sv ----
/*
  bench for lpw_wake_ctrl: AHB-Lite master, cpu model, queued checks.
  assumes the start-up count is shortened to four cycles.
*/
`timescale 1ns/1ps
`include "lpw_cfg.svh"
module lpw_wake_ctrl_bench;
  localparam int unsigned OST_CYC = 4;
  logic        hclk, hresetn, hsel, hwrite, rd_dp, go_halt, irq_on, irq;
  logic        hreadyout, hresp, halt_req, irq_req, wdog_expire, wdog_clear;
  logic        dbg_active, failsafe_clock_monitor_switch, osc_needs_start, cpu_halted;
  logic        cpu_sleep, nmi_reset_vec, irq_wake;
  logic [1:0]  htrans;
  logic [2:0]  irq_prio, clk_mode, failsafe_clock_monitor_mode, prio_in, p;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [33:0] exp_q[$];
  int          err_total, checks_done, n_clr;

  lpw_wake_ctrl #(.OST_CYC(OST_CYC)) u_lpw_wake_ctrl (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .halt_req, .irq_req,
    .irq_prio, .wdog_expire, .dbg_active, .failsafe_clock_monitor_switch, .failsafe_clock_monitor_mode,
    .osc_needs_start, .cpu_halted, .cpu_sleep, .nmi_reset_vec, .irq_wake,
    .wdog_clear, .clk_mode, .irq);
  lpw_cpu_model u_lpw_cpu_model (.hclk, .hresetn, .go_halt, .irq_on,
    .prio_in, .irq_wake, .halt_req, .irq_req, .irq_prio);

  initial begin
    {hclk, hresetn, hsel, hwrite, rd_dp, go_halt, irq_on} = '0;
    {wdog_expire, dbg_active, failsafe_clock_monitor_switch, osc_needs_start} = '0;
    {htrans, failsafe_clock_monitor_mode, prio_in, haddr, hwdata} = '0;
    {err_total, checks_done, n_clr} = '0;
    seed = 32'h9bbb;
    forever #20 hclk = ~hclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [33:0] pop;
    return exp_q.size() > 0 ? exp_q.pop_front() : '1;
  endfunction
  task automatic results;
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ck(input logic [33:0] got, input logic [33:0] want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic quit;
    ck(34'h0, 34'h1);
    results();
  endtask
  // k: 0 halted, 1 wake pulse, 2 bus ready
  task automatic wt(input int k);
    int n;
    n = 0;
    do begin
      if (k == 2) @(posedge hclk);
      else @(negedge hclk);
      if (++n > 60) quit();
    end while ((k == 2 ? hreadyout : k == 1 ? nmi_reset_vec | irq_wake
                : cpu_halted) !== 1'b1);
  endtask
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wt(2);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    wt(2);
    // slave must always answer okay
    ck({33'h0, hresp}, 34'h0);
    rd_dp <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({2'h0, e});
    bus(0, a, 32'h0);
  endtask
  task automatic halt;
    @(posedge hclk);
    go_halt <= 1'b1;
    @(posedge hclk);
    go_halt <= 1'b0;
    wt(0);
  endtask
  task automatic wd;
    @(posedge hclk);
    wdog_expire <= 1'b1;
    @(posedge hclk);
    wdog_expire <= 1'b0;
  endtask

  // read data and wake pulses are matched against the oldest note
  always @(negedge hclk) begin
    if (wdog_clear === 1'b1) n_clr++;
    if (rd_dp) ck({2'h0, hrdata}, pop());
    if (nmi_reset_vec | irq_wake) ck({32'h1, irq_wake, nmi_reset_vec}, pop());
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    dbg_active <= 1'b1;
    osc_needs_start <= 1'b1;
    bus(1, `LPW_OFS_OSCCTL, 32'h5);
    repeat (2) @(negedge hclk);
    ck({31'h0, clk_mode}, 34'h0);
    ck({33'h0, irq}, 34'h0);
    bus(1, `LPW_OFS_IRQ_MASK, 32'h8);
    repeat (2) @(negedge hclk);
    ck({33'h0, irq}, 34'h1);
    seed = xs(seed);
    @(posedge hclk);
    failsafe_clock_monitor_mode <= {seed[2:1], 1'b1};
    failsafe_clock_monitor_switch <= 1'b1;
    @(posedge hclk);
    failsafe_clock_monitor_switch <= 1'b0;
    repeat (2) @(negedge hclk);
    ck({31'h0, clk_mode}, {31'h0, seed[2:1], 1'b1});
    rd(`LPW_OFS_IRQ_STAT, 32'hc);
    rd(8'h20, 32'h0);
    ck({33'h0, irq}, 34'h0);
    dbg_active <= 1'b0;
    bus(1, `LPW_OFS_CORECTL, 32'h2);
    for (int d = 0; d < 2; d++) begin
      bus(1, `LPW_OFS_OSCCTL, {27'h0, d[0], 4'h3});
      halt();
      ck({33'h0, cpu_sleep}, {33'h0, d[0]});
      repeat (3) @(posedge hclk);
      exp_q.push_back({32'h1, 2'h1});
      wd();
      wt(1);
      rd(`LPW_OFS_RCAUSE, {28'h1, d[0], 3'h4});
      bus(1, `LPW_OFS_RCAUSE, 32'h0);
      rd(`LPW_OFS_RCAUSE, 32'h0);
    end
    ck({31'h0, clk_mode}, 34'h3);
    bus(1, `LPW_OFS_OSCCTL, 32'h3);
    @(posedge hclk);
    go_halt <= 1'b1;
    irq_on <= 1'b1;
    prio_in <= 3'h5;
    exp_q.push_back({32'h1, 2'h2});
    @(posedge hclk);
    go_halt <= 1'b0;
    wt(1);
    @(posedge hclk);
    irq_on <= 1'b0;
    rd(`LPW_OFS_RCAUSE, 32'h4);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      p = i == 0 ? 3'h0 : i == 1 ? 3'h2 : i == 2 ? 3'h3 + seed[1:0] : 3'h7;
      halt();
      repeat (3) @(posedge hclk);
      irq_on <= 1'b1;
      prio_in <= p;
      exp_q.push_back({32'h1, p > 2 ? 2'h2 : 2'h1});
      repeat (i == 3 ? 0 : 6) @(posedge hclk);
      @(negedge hclk);
      ck({33'h0, cpu_halted}, {33'h0, p < 3 || i == 3});
      wd();
      if (p < 3 || i == 3) wt(1);
      @(posedge hclk);
      irq_on <= 1'b0;
    end
    ck({2'h0, 32'(n_clr)}, 34'd7);
    rd(`LPW_OFS_CLKSTAT, 32'h3);
    rd(`LPW_OFS_IRQ_MASK, 32'h8);
    rd(`LPW_OFS_CORECTL, 32'h2);
    repeat (2) @(negedge hclk);
    // a missed wake or read leaves a note behind
    ck({2'h0, 32'(exp_q.size())}, 34'h0);
    results();
  end
endmodule

bind lpw_wake_ctrl lpw_chk #(.OST_CYC(OST_CYC)) u_lpw_chk (.hclk, .hresetn,
  .dbg_active, .failsafe_clock_monitor_switch, .osc_needs_start, .cpu_halted, .cpu_sleep,
  .nmi_reset_vec, .irq_wake, .wdog_clear, .clk_mode);
